/* File: dacc_cfg.svh */
`ifndef DACC_CFG_SVH
`define DACC_CFG_SVH

// ----------------------------------------------------------------------
// serial frame layout
// ----------------------------------------------------------------------
`define DACC_FRAME_BITS   24
`define DACC_RW_BIT       23
`define DACC_ADDR_MSB     22
`define DACC_ADDR_LSB     20
`define DACC_DATA_MSB     19
`define DACC_DATA_LSB     4

// ----------------------------------------------------------------------
// device register addresses
// ----------------------------------------------------------------------
`define DACC_ADDR_DAC     3'h1
`define DACC_ADDR_CTRL    3'h2
`define DACC_ADDR_CLEAR   3'h3
`define DACC_ADDR_SWCTL   3'h4

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define DACC_SW_LOAD_BIT  0
`define DACC_SW_CLEAR_BIT 1
`define DACC_SW_RESET_BIT 2
`define DACC_CTL_FEEDBACK_RESISTOR_SELECT_BIT 1
`define DACC_CTL_GND_BIT  2
`define DACC_CTL_TRI_BIT  3
`define DACC_CTL_FMT_BIT  4
`define DACC_CTL_SDO_BIT  5

// ----------------------------------------------------------------------
// reset values and sign flip mask
// ----------------------------------------------------------------------
`define DACC_DAC_RST      16'h8000
`define DACC_CLEAR_RST    16'h0000
`define DACC_SIGN_FLIP    16'h8000
`define DACC_FEEDBACK_RESISTOR_SELECT_RST     1'b1
`define DACC_GND_RST      1'b1
`define DACC_TRI_RST      1'b1
`define DACC_FMT_RST      1'b0
`define DACC_SDODIS_RST   1'b0

// ----------------------------------------------------------------------
// host register offsets and timing
// ----------------------------------------------------------------------
`define DACC_HOST_TX      8'h00
`define DACC_HOST_STAT    8'h04
`define DACC_HOST_RX      8'h08
`define DACC_HOST_PINS    8'h0C
`define DACC_SCLK_HALF    8

`endif

/* File: dacc_pkg.sv */
`include "dacc_cfg.svh"

package dacc_pkg;

    // ------------------------------------------------------------------
    // output state of the converter
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_NORMAL   = 2'b00,
        MODE_CLAMP    = 2'b01,
        MODE_TRISTATE = 2'b10
    } dacc_mode_type;

    // ------------------------------------------------------------------
    // host frame engine states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_LOW  = 2'b01,
        HS_HIGH = 2'b10,
        HS_GAP  = 2'b11
    } dacc_hstate_type;

    // ------------------------------------------------------------------
    // device state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                sclk_d;
        logic                sync_d;
        logic                load_d;
        logic                clear_d;
        logic [4:0]          bit_cnt;
        logic [23:0]         rx_sh;
        logic [23:0]         tx_sh;
        logic                sdo;
        logic                frame_on;
        logic [15:0]         inp_reg;
        logic [15:0]         dac_reg;
        logic [15:0]         clear_code;
        logic                output_tristate_ctl;
        logic                output_ground_clamp;
        logic                feedback_resistor_select;
        logic                code_format_select;
        logic                sdo_disable;
        logic [15:0]         out_code;
        dacc_mode_type       out_mode;
    } dacc_dev_type;

    // ------------------------------------------------------------------
    // host state
    // ------------------------------------------------------------------
    typedef struct packed {
        dacc_hstate_type     state;
        logic [7:0]          div;
        logic [4:0]          bits;
        logic [23:0]         tx;
        logic [23:0]         rx;
        logic                sclk;
        logic                sync_n;
        logic                sdin;
        logic                load_n;
        logic                clear_n;
        logic                a_wr;
        logic [7:0]          a_addr;
        logic [31:0]         hrdata;
    } dacc_host_type;

endpackage : dacc_pkg

/* File: dacc_link_if.sv */
`timescale 1ns/1ns

interface dacc_link_if;
    logic sclk;
    logic sync_n;
    logic sdin;
    logic sdo_out;
    logic sdo_oe;
    logic sdo;
    logic load_output_strobe_n;
    logic clear_to_code_strobe_n;

    // undriven readback line idles high
    assign sdo = sdo_oe ? sdo_out : 1'b1;

    modport host (
        output sclk,
        output sync_n,
        output sdin,
        output load_output_strobe_n,
        output clear_to_code_strobe_n,
        input  sdo
    );

    modport device (
        input  sclk,
        input  sync_n,
        input  sdin,
        input  load_output_strobe_n,
        input  clear_to_code_strobe_n,
        output sdo_out,
        output sdo_oe
    );
endinterface : dacc_link_if

/* File: dacc_sync.sv */
`timescale 1ns/1ns

module dacc_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // level in and out
    input  wire logic [W-1:0] din,
    output      logic [W-1:0] dout
);
    logic [1:0][W-1:0] meta_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= {RST_VAL, RST_VAL};
        end else begin
            meta_r <= {meta_r[0], din};
        end
    end

    assign dout = meta_r[1];
endmodule : dacc_sync

/* File: dacc_device.sv */
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ns

`include "dacc_cfg.svh"

module dacc_device
    import dacc_pkg::*;
(
    // clock and reset
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    // serial link
    dacc_link_if.device                  link,
    // converter side
    output      logic [15:0]             dac_code,
    output      dacc_pkg::dacc_mode_type out_mode,
    output      logic                    reference_connect,
    output      logic                    feedback_resistor_select,
    output      logic                    code_format_select
);
    import dacc_pkg::*;

    // ------------------------------------------------------------------
    // reset image
    // ------------------------------------------------------------------
    localparam dacc_dev_type DEV_RST = '{
        sclk_d:                   1'b0,
        sync_d:                   1'b1,
        load_d:                   1'b1,
        clear_d:                  1'b1,
        bit_cnt:                  5'h00,
        rx_sh:                    24'h00_0000,
        tx_sh:                    24'h00_0000,
        sdo:                      1'b0,
        frame_on:                 1'b0,
        inp_reg:                  `DACC_DAC_RST,
        dac_reg:                  `DACC_DAC_RST,
        clear_code:               `DACC_CLEAR_RST,
        output_tristate_ctl:      `DACC_TRI_RST,
        output_ground_clamp:      `DACC_GND_RST,
        feedback_resistor_select: `DACC_FEEDBACK_RESISTOR_SELECT_RST,
        code_format_select:       `DACC_FMT_RST,
        sdo_disable:              `DACC_SDODIS_RST,
        out_code:                 16'h0000,
        out_mode:                 MODE_CLAMP
    };

    dacc_dev_type st_r;
    dacc_dev_type st_nxt;

    logic [4:0] pins_s;
    logic       sclk_s;
    logic       sync_s;
    logic       sdin_s;
    logic       load_s;
    logic       clear_s;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    dacc_sync #(
        .W       (5),
        .RST_VAL (5'h1A)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .din     ({link.clear_to_code_strobe_n,
                   link.load_output_strobe_n,
                   link.sdin, link.sync_n, link.sclk}),
        .dout    (pins_s)
    );

    assign sclk_s  = pins_s[0];
    assign sync_s  = pins_s[1];
    assign sdin_s  = pins_s[2];
    assign load_s  = pins_s[3];
    assign clear_s = pins_s[4];

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic        sclk_rise;
        logic        sclk_fall;
        logic        frame_end;
        logic        load_req;
        logic        clear_req;
        logic        sw_reset;
        logic [2:0]  addr;
        logic [15:0] data;
        logic [15:0] rdata;

        st_nxt    = st_r;
        sclk_rise = sclk_s & ~st_r.sclk_d;
        sclk_fall = ~sclk_s & st_r.sclk_d;
        frame_end = sync_s & ~st_r.sync_d;
        addr      = st_r.rx_sh[`DACC_ADDR_MSB:`DACC_ADDR_LSB];
        data      = st_r.rx_sh[`DACC_DATA_MSB:`DACC_DATA_LSB];
        sw_reset  = 1'b0;
        rdata     = 16'h0000;

        st_nxt.sclk_d  = sclk_s;
        st_nxt.sync_d  = sync_s;
        st_nxt.load_d  = load_s;
        st_nxt.clear_d = clear_s;

        // pin strobes act on the falling edge
        load_req  = st_r.load_d & ~load_s;
        clear_req = st_r.clear_d & ~clear_s;

        if (st_r.sync_d & ~sync_s) begin
            st_nxt.bit_cnt  = 5'h00;
            st_nxt.frame_on = 1'b1;
        end

        // readback bits change on the rising clock edge
        if (sclk_rise & st_r.frame_on) begin
            st_nxt.sdo   = st_r.tx_sh[23];
            st_nxt.tx_sh = {st_r.tx_sh[22:0], 1'b0};
        end

        if (sclk_fall & st_r.frame_on) begin
            st_nxt.rx_sh = {st_r.rx_sh[22:0], sdin_s};
            if (st_r.bit_cnt != 5'(`DACC_FRAME_BITS)) begin
                st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
            end
        end

        if (frame_end) begin
            st_nxt.frame_on = 1'b0;
        end

        if (frame_end && st_r.frame_on &&
            st_r.bit_cnt == 5'(`DACC_FRAME_BITS)) begin
            if (!st_r.rx_sh[`DACC_RW_BIT]) begin
                unique case (addr)
                    `DACC_ADDR_DAC: begin
                        st_nxt.inp_reg = data;
                        // load pin held low, clear pin high: direct update
                        if (!load_s && clear_s) begin
                            st_nxt.dac_reg = data;
                        end
                    end
                    `DACC_ADDR_CTRL: begin
                        st_nxt.feedback_resistor_select =
                            st_r.rx_sh[`DACC_CTL_FEEDBACK_RESISTOR_SELECT_BIT];
                        st_nxt.output_ground_clamp =
                            st_r.rx_sh[`DACC_CTL_GND_BIT];
                        st_nxt.output_tristate_ctl =
                            st_r.rx_sh[`DACC_CTL_TRI_BIT];
                        st_nxt.code_format_select =
                            st_r.rx_sh[`DACC_CTL_FMT_BIT];
                        st_nxt.sdo_disable =
                            st_r.rx_sh[`DACC_CTL_SDO_BIT];
                    end
                    `DACC_ADDR_CLEAR: begin
                        st_nxt.clear_code = data;
                    end
                    `DACC_ADDR_SWCTL: begin
                        load_req  = load_req |
                            st_r.rx_sh[`DACC_SW_LOAD_BIT];
                        clear_req = clear_req |
                            st_r.rx_sh[`DACC_SW_CLEAR_BIT];
                        sw_reset  = st_r.rx_sh[`DACC_SW_RESET_BIT];
                    end
                    default: begin
                    end
                endcase
            end else begin
                unique case (addr)
                    `DACC_ADDR_DAC: rdata = st_r.dac_reg;
                    `DACC_ADDR_CLEAR: rdata = st_r.clear_code;
                    `DACC_ADDR_CTRL: begin
                        rdata[`DACC_CTL_FEEDBACK_RESISTOR_SELECT_BIT] =
                            st_r.feedback_resistor_select;
                        rdata[`DACC_CTL_GND_BIT] = st_r.output_ground_clamp;
                        rdata[`DACC_CTL_TRI_BIT] = st_r.output_tristate_ctl;
                        rdata[`DACC_CTL_FMT_BIT] = st_r.code_format_select;
                        rdata[`DACC_CTL_SDO_BIT] = st_r.sdo_disable;
                    end
                    default: rdata = 16'h0000;
                endcase
                if (addr == `DACC_ADDR_CTRL) begin
                    st_nxt.tx_sh = {st_r.rx_sh[23:20], 4'h0, rdata};
                end else begin
                    st_nxt.tx_sh = {st_r.rx_sh[23:20], rdata, 4'h0};
                end
            end
        end

        // clear blocked by low load pin
        clear_req = clear_req & load_s;
        // load blocked by low clear pin
        load_req  = load_req & clear_s;

        if (clear_req) begin
            st_nxt.dac_reg = st_nxt.clear_code;
        end else if (load_req) begin
            st_nxt.dac_reg = st_nxt.inp_reg;
        end

        if (sw_reset) begin
            st_nxt         = DEV_RST;
            st_nxt.sclk_d  = sclk_s;
            st_nxt.sync_d  = sync_s;
            st_nxt.load_d  = load_s;
            st_nxt.clear_d = clear_s;
        end

        // reset code maps to negative reference
        st_nxt.out_code = st_nxt.code_format_select ? st_nxt.dac_reg :
                          st_nxt.dac_reg ^ `DACC_SIGN_FLIP;

        if (st_nxt.output_ground_clamp) begin
            st_nxt.out_mode = MODE_CLAMP;
        end else if (st_nxt.output_tristate_ctl) begin
            st_nxt.out_mode = MODE_TRISTATE;
        end else begin
            st_nxt.out_mode = MODE_NORMAL;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // defaults on power-on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= DEV_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign link.sdo_out              = st_r.sdo;
    assign link.sdo_oe               = st_r.frame_on & ~st_r.sdo_disable;
    assign dac_code                  = st_r.out_code;
    assign out_mode                  = st_r.out_mode;
    assign reference_connect         = (st_r.out_mode == MODE_NORMAL);
    assign feedback_resistor_select  = st_r.feedback_resistor_select;
    assign code_format_select        = st_r.code_format_select;
endmodule : dacc_device

/* File: dacc_host.sv */
`timescale 1ns/1ns

`include "dacc_cfg.svh"

module dacc_host
    import dacc_pkg::*;
#(
    parameter int SCLK_HALF = `DACC_SCLK_HALF
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output      logic        hreadyout,
    output      logic [31:0] hrdata,
    output      logic        hresp,
    // serial link
    dacc_link_if.host        link
);
    import dacc_pkg::*;

    localparam logic [7:0] HALF_M1 = 8'(SCLK_HALF - 1);

    localparam dacc_host_type HOST_RST = '{
        state:   HS_IDLE,
        div:     8'h00,
        bits:    5'h00,
        tx:      24'h00_0000,
        rx:      24'h00_0000,
        sclk:    1'b0,
        sync_n:  1'b1,
        sdin:    1'b0,
        load_n:  1'b1,
        clear_n: 1'b1,
        a_wr:    1'b0,
        a_addr:  8'h00,
        hrdata:  32'h0000_0000
    };

    dacc_host_type st_r;
    dacc_host_type st_nxt;
    logic          sdo_s;

    dacc_sync #(
        .W       (1),
        .RST_VAL (1'b1)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .din     (link.sdo),
        .dout    (sdo_s)
    );

    // ------------------------------------------------------------------
    // bus access and frame engine
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt      = st_r;
        st_nxt.a_wr = 1'b0;

        // data phase of a write
        if (st_r.a_wr) begin
            unique case (st_r.a_addr)
                `DACC_HOST_TX: begin
                    if (st_r.state == HS_IDLE) begin
                        st_nxt.state  = HS_LOW;
                        st_nxt.div    = HALF_M1;
                        st_nxt.bits   = 5'(`DACC_FRAME_BITS);
                        st_nxt.tx     = hwdata[23:0];
                        st_nxt.sdin   = hwdata[23];
                        st_nxt.sync_n = 1'b0;
                    end
                end
                `DACC_HOST_PINS: begin
                    st_nxt.load_n  = hwdata[0];
                    st_nxt.clear_n = hwdata[1];
                end
                default: begin
                end
            endcase
        end

        unique case (st_r.state)
            HS_IDLE: begin
            end
            HS_LOW: begin
                if (st_r.div == 8'h00) begin
                    st_nxt.sclk  = 1'b1;
                    st_nxt.sdin  = st_r.tx[23];
                    st_nxt.div   = HALF_M1;
                    st_nxt.state = HS_HIGH;
                end else begin
                    st_nxt.div = st_r.div - 8'h01;
                end
            end
            HS_HIGH: begin
                if (st_r.div == 8'h00) begin
                    st_nxt.sclk = 1'b0;
                    st_nxt.rx   = {st_r.rx[22:0], sdo_s};
                    st_nxt.tx   = {st_r.tx[22:0], 1'b0};
                    st_nxt.bits = st_r.bits - 5'h01;
                    st_nxt.div  = HALF_M1;
                    st_nxt.state = (st_r.bits == 5'h01) ? HS_GAP : HS_LOW;
                end else begin
                    st_nxt.div = st_r.div - 8'h01;
                end
            end
            HS_GAP: begin
                if (st_r.div != 8'h00) begin
                    st_nxt.div = st_r.div - 8'h01;
                end else if (!st_r.sync_n) begin
                    st_nxt.sync_n = 1'b1;
                    st_nxt.div    = HALF_M1;
                end else begin
                    st_nxt.state = HS_IDLE;
                end
            end
        endcase

        // address phase
        if (hsel && htrans[1] && hready) begin
            st_nxt.a_wr   = hwrite;
            st_nxt.a_addr = haddr[7:0];
            if (!hwrite) begin
                unique case (haddr[7:0])
                    `DACC_HOST_TX:
                        st_nxt.hrdata = {8'h00, st_nxt.tx};
                    `DACC_HOST_STAT:
                        st_nxt.hrdata = {31'h0000_0000,
                                         st_nxt.state != HS_IDLE};
                    `DACC_HOST_RX:
                        st_nxt.hrdata = {8'h00, st_nxt.rx};
                    `DACC_HOST_PINS:
                        st_nxt.hrdata = {30'h0000_0000, st_nxt.clear_n,
                                         st_nxt.load_n};
                    default:
                        st_nxt.hrdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= HOST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign hreadyout                   = 1'b1;
    assign hresp                       = 1'b0;
    assign hrdata                      = st_r.hrdata;
    assign link.sclk                   = st_r.sclk;
    assign link.sync_n                 = st_r.sync_n;
    assign link.sdin                   = st_r.sdin;
    assign link.load_output_strobe_n   = st_r.load_n;
    assign link.clear_to_code_strobe_n = st_r.clear_n;
endmodule : dacc_host

/* File: dacc_checker.sv */
`timescale 1ns/1ns
module dacc_checker
    import dacc_pkg::*;
(
    // clock and reset
    input wire logic          hclk,
    input wire logic          hresetn,
    // link and converter
    input wire logic          sclk,
    input wire logic          sync_n,
    input wire logic          load_output_strobe_n,
    input wire logic          clear_to_code_strobe_n,
    input wire logic [15:0]   dac_code,
    input wire dacc_mode_type out_mode,
    input wire logic          reference_connect
);
    logic       sclk_q;
    logic [4:0] rises_r;
    logic [3:0] quiet_r;
    logic [3:0] since_r;
    logic       ev;
    assign ev = !sync_n || !load_output_strobe_n || !clear_to_code_strobe_n;
    // ----
    // event counters
    // ----
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_q  <= 1'b0;
            rises_r <= 5'h0;
            quiet_r <= 4'h0;
            since_r <= 4'h0;
        end else begin
            sclk_q  <= sclk;
            rises_r <= sync_n ? 5'h0 : rises_r + 5'(sclk && !sclk_q);
            quiet_r <= ev ? 4'h0 : quiet_r + 4'(quiet_r != 4'hf);
            since_r <= !sync_n ? 4'h0 : since_r + 4'(since_r != 4'hf);
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_sclk_idle_low: assert property (sync_n |-> !sclk)
        else $error("sclk high outside frame");
    a_sync_lead: assert property ($fell(sync_n) |-> !sclk [*7])
        else $error("sclk rose too early");
    a_sclk_high_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
        else $error("sclk high phase wrong");
    a_frame_bit_count: assert property ($rose(sync_n) |-> rises_r == 5'd24)
        else $error("frame not 24 bits");
    a_ref_follows_mode: assert property (reference_connect == (out_mode == MODE_NORMAL))
        else $error("reference connect wrong");
    a_reset_clamp: assert property (disable iff (1'b0)
        !hresetn |-> out_mode == MODE_CLAMP && dac_code == 16'h0000)
        else $error("reset state wrong");
    a_mode_after_frame: assert property (!$stable(out_mode) |->
        since_r inside {[4'h1:4'hc]})
        else $error("mode changed without frame");
    a_code_held_quiet: assert property (quiet_r == 4'hf |-> $stable(dac_code))
        else $error("code changed without request");
    c_frame_done: cover property ($rose(sync_n));
    c_normal_mode: cover property (out_mode == MODE_NORMAL);
    c_clear_pin: cover property (!clear_to_code_strobe_n);
endmodule : dacc_checker

/* File: test_dacc_output_control_regs.sv */
`timescale 1ns/1ns
module test_dacc_output_control_regs;
    import dacc_pkg::*;
    logic          hclk    = 1'b0;
    logic          hresetn = 1'b1;
    logic [31:0]   haddr   = 32'h0;
    logic [1:0]    htrans  = 2'b00;
    logic          hwrite  = 1'b0;
    logic [31:0]   hwdata  = 32'h0;
    logic          hready;
    logic [31:0]   hrdata;
    logic [31:0]   q;
    logic [15:0]   dac_code;
    dacc_mode_type out_mode;
    logic          ref_on;
    logic          fb;
    logic          fmt;
    int            errors = 0;
    int            comparisons = 0;
    dacc_link_if link ();
    dacc_host i_dacc_host (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout(hready),
        .hrdata, .hresp(), .link(link.host));
    dacc_device i_dacc_device (.hclk, .hresetn, .link(link.device),
        .dac_code, .out_mode, .reference_connect(ref_on),
        .feedback_resistor_select(fb), .code_format_select(fmt));
    dacc_checker i_dacc_checker (.hclk, .hresetn, .sclk(link.sclk),
        .sync_n(link.sync_n), .load_output_strobe_n(link.load_output_strobe_n),
        .clear_to_code_strobe_n(link.clear_to_code_strobe_n), .dac_code,
        .out_mode, .reference_connect(ref_on));
    initial forever #10 hclk = ~hclk;
    // ----
    // bus and check helpers
    // ----
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h0, a};
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        q = hrdata;
    endtask : ahb
    task automatic frame(input logic [3:0] a, input logic [19:0] d);
        ahb(1'b1, 8'h00, {8'h00, a, d});
        q = 32'h1;
        while (q[0] !== 1'b0) ahb(1'b0, 8'h04, 32'h0);
        repeat (8) @(posedge hclk);
    endtask : frame
    task automatic pins(input logic ld, input logic cl);
        ahb(1'b1, 8'h0C, {30'h0, cl, ld});
        repeat (8) @(posedge hclk);
    endtask : pins
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // ----
    // scenarios
    // ----
    task automatic t_power_on;
        chk({fb, fmt, ref_on, out_mode}, {3'b100, MODE_CLAMP});
        chk(dac_code, 16'h0000);
    endtask : t_power_on
    task automatic t_modes;
        frame(3'h2, 20'h0_0008);
        chk(out_mode, MODE_TRISTATE);
        frame(3'h2, 20'h0_000C);
        chk(out_mode, MODE_CLAMP);
        frame(3'h2, 20'h0_0000);
        chk({fb, ref_on, out_mode}, {2'b01, MODE_NORMAL});
        chk(dac_code, 16'h0000);
        frame(3'h2, 20'h0_0002);
        chk(fb, 1'b1);
    endtask : t_modes
    task automatic t_strobes;
        frame(3'h1, {16'h1234, 4'h0});
        chk(dac_code, 16'h0000);
        frame(3'h4, 20'h0_0001);
        chk(dac_code, 16'h9234);
        frame(3'h3, {16'h5678, 4'hF});
        frame(4'hB, 20'h0_0000);
        frame(4'h0, 20'h0_0000);
        ahb(1'b0, 8'h08, 32'h0);
        chk(q, {8'h00, 4'hB, 16'h5678, 4'h0});
        frame(3'h4, 20'h0_0002);
        chk(dac_code, 16'hD678);
        frame(3'h2, 20'h0_0012);
        frame(3'h4, 20'h0_0002);
        chk(dac_code, 16'h5678);
        frame(3'h4, 20'hF_FFF8);
        chk(dac_code, 16'h5678);
    endtask : t_strobes
    task automatic t_pins;
        frame(3'h1, {16'h1111, 4'h0});
        pins(1'b0, 1'b1);
        chk(dac_code, 16'h1111);
        frame(3'h4, 20'h0_0002);
        chk(dac_code, 16'h1111);
        pins(1'b1, 1'b1);
        pins(1'b1, 1'b0);
        chk(dac_code, 16'h5678);
        frame(3'h1, {16'h2222, 4'h0});
        frame(3'h4, 20'h0_0001);
        chk(dac_code, 16'h5678);
        pins(1'b1, 1'b1);
    endtask : t_pins
    task automatic t_reset;
        frame(3'h4, 20'h0_0004);
        chk({fmt, out_mode, dac_code}, {1'b0, MODE_CLAMP, 16'h0000});
    endtask : t_reset
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        t_power_on;
        t_modes;
        t_strobes;
        t_pins;
        t_reset;
        report_and_stop;
    end
    initial begin
        #1_000_000;
        errors++;
        report_and_stop;
    end
endmodule : test_dacc_output_control_regs
